//--- pkg/sysref_regs_pkg.sv
package sysref_regs_pkg;

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_SRC_CTRL   = 10'h139;
    localparam logic [9:0] IDX_DIV_HIGH   = 10'h13A;
    localparam logic [9:0] IDX_DIV_LOW    = 10'h13B;
    localparam logic [9:0] IDX_DLY_HIGH   = 10'h13C;
    localparam logic [9:0] IDX_DLY_LOW    = 10'h13D;
    localparam logic [9:0] IDX_BURST_LEN  = 10'h13E;
    localparam logic [9:0] IDX_LOOP_FB    = 10'h13F;
    localparam logic [9:0] IDX_POWER      = 10'h140;
    localparam logic [9:0] IDX_STATUS     = 10'h150;
    localparam logic [9:0] IDX_SYNC_CTRL  = 10'h151;

    // reset values
    localparam logic [7:0] RST_SRC_CTRL   = 8'h00;
    localparam logic [7:0] RST_DIV_HIGH   = 8'h0C;
    localparam logic [7:0] RST_DIV_LOW    = 8'h00;
    localparam logic [7:0] RST_DLY_HIGH   = 8'h00;
    localparam logic [7:0] RST_DLY_LOW    = 8'h08;
    localparam logic [7:0] RST_BURST_LEN  = 8'h03;
    localparam logic [7:0] RST_LOOP_FB    = 8'h00;
    localparam logic [7:0] RST_POWER      = 8'h00;
    localparam logic [7:0] RST_SYNC_CTRL  = 8'h00;

    // writable bits
    localparam logic [7:0] MASK_SRC_CTRL  = 8'h1B;
    localparam logic [7:0] MASK_HIGH      = 8'h1F;
    localparam logic [7:0] MASK_BURST_LEN = 8'h03;
    localparam logic [7:0] MASK_LOOP_FB   = 8'hBF;
    localparam logic [7:0] MASK_POWER     = 8'h05;
    localparam logic [7:0] MASK_SYNC_CTRL = 8'h01;

    // field positions
    localparam int SRC_SEL_LSB    = 0;
    localparam int SYNC_BYP_BIT   = 3;
    localparam int REQ_EN_BIT     = 4;
    localparam int HIGH_FIELD_W   = 5;
    localparam int RCLK_SEL_BIT   = 7;
    localparam int NCLK2_SEL_BIT  = 5;
    localparam int NCLK1_SEL_LSB  = 3;
    localparam int FB_CTRL_LSB    = 0;
    localparam int SYSREF_POWER_DOWN_BIT  = 2;
    localparam int PULSER_PD_BIT  = 0;
    localparam int SYNC_INV_BIT   = 0;

    // limits
    localparam int VAL_W               = 13;
    localparam logic [12:0] MIN_VALUE  = 13'h0008;
    localparam logic [12:0] RST_DIVIDE = {RST_DIV_HIGH[4:0], RST_DIV_LOW};
    localparam logic [12:0] RST_DELAY  = {RST_DLY_HIGH[4:0], RST_DLY_LOW};

    typedef enum logic [1:0] {
        SRC_SYNC   = 2'b00,
        SRC_RECLK  = 2'b01,
        SRC_PULSER = 2'b10,
        SRC_CONT   = 2'b11
    } sysref_src_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } gen_state_t;

endpackage

//--- src/pin_sync2.sv
`timescale 1ns/1ps
module pin_sync2 (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rstn,
    // pin and synchronised level
    input  wire logic i_pin,
    output logic      o_level
);
    logic meta;

    // two flop synchroniser
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta    <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta    <= i_pin;
            o_level <= meta;
        end
    end
endmodule

//--- src/sysref_divider.sv
`timescale 1ns/1ps
module sysref_divider (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rstn,
    // control
    input  wire logic        i_run,
    input  wire logic [12:0] i_divide,
    // divided clock
    output logic             o_level,
    output logic             o_period_end
);
    logic [12:0] count;

    // phase counter
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count <= 13'h0000;
        end else if (!i_run || count == i_divide - 13'h0001) begin
            count <= 13'h0000;
        end else begin
            count <= count + 13'h0001;
        end
    end

    // high in first half
    assign o_level      = i_run && (count < (i_divide >> 1));
    assign o_period_end = i_run && (count == i_divide - 13'h0001);
endmodule

//--- src/sysref_sync_feedback_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) source select 0 is plain sync, 1 re-clocked, 2 pulser, 3 continuous.
// (RULE2) with request enable set, the request pin high forces the continuous source.
// (RULE3) software using the request pin keeps the pulser on and selects it.
// (RULE4) sync bypass 0 filters sync, inverted when the sync invert bit is set, 1 uses it directly.
// (RULE5) divide value is low five bits of the high register over the whole low register.
// (RULE6) divide values 0 to 7 are reserved, 8 to 8191 divide by exactly that value.
// (RULE7) delay value splits the same way, below 8 reserved, 8 to 8191 give that count.
// (RULE8) burst code 0, 1, 2, 3 gives 1, 2, 4, 8 pulses.
// (RULE9) writing burst length starts a burst when pulser is selected and powered.
// (RULE10) burst length is ignored while the source is continuous.
// (RULE11) second loop reference select 0 is oscillator, 1 selected reference.
// (RULE12) second loop divider input select 0 is prescaler, 1 feedback mux.
// (RULE13) first loop divider input 0 oscillator, 1 feedback mux, 2 second loop prescaler.
// (RULE14) sysref power down stops sysref circuitry, divider and sync.
// (RULE15) pulser power down stops the pulse generator and its bursts.
// (RULE16) reserved bits are written as zero, ignored and read back as zero.
// (RULE17) a split value takes effect whole on the low write, never as reserved.
module sysref_sync_feedback_regs (
    // clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rstn,
    // ahb-lite slave
    input  wire logic                        i_hsel,
    input  wire logic [31:0]                 i_haddr,
    input  wire logic [1:0]                  i_htrans,
    input  wire logic                        i_hwrite,
    input  wire logic [2:0]                  i_hsize,
    input  wire logic [31:0]                 i_hwdata,
    input  wire logic                        i_hready,
    output logic                             o_hreadyout,
    output logic                             o_hresp,
    output logic [31:0]                      o_hrdata,
    // sync and request pin
    input  wire logic                        i_sync_request_pin,
    // sysref generation
    output logic                             o_sysref,
    output logic                             o_sync_out,
    output sysref_regs_pkg::sysref_src_t     o_active_source,
    output logic                             o_burst_busy,
    // loop input selects and values
    output logic                             o_second_loop_reference_select,
    output logic                             o_second_loop_divider_input_select,
    output logic [1:0]                       o_first_loop_divider_input_select,
    output logic [2:0]                       o_feedback_mux_ctrl,
    output logic [12:0]                      o_sysref_divide_value,
    output logic [12:0]                      o_sysref_delay_value
);
    import sysref_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic        wr_pend;
    logic [9:0]  wr_idx;
    logic        rd_wait;
    logic [9:0]  rd_idx;
    logic [7:0]  wdat;
    logic [7:0]  src_ctrl;
    logic [7:0]  div_high;
    logic [7:0]  div_low;
    logic [7:0]  dly_high;
    logic [7:0]  dly_low;
    logic [7:0]  burst_len;
    logic [7:0]  loop_fb;
    logic [7:0]  power;
    logic [7:0]  sync_ctrl;
    logic [7:0]  status;
    logic [7:0]  rd_byte;
    logic [12:0] div_cand;
    logic [12:0] dly_cand;
    logic        sync_level;
    logic        filt_prev;
    logic        filt_level;
    logic        sync_path;
    logic        sync_reclk;
    logic        sysref_up;
    logic        pulser_up;
    logic        continuous;
    logic        burst_go;
    logic        burst_mode;
    logic [3:0]  remaining;
    logic [12:0] dly_count;
    logic        div_level;
    logic        div_end;
    gen_state_t  state;
    sysref_src_t eff_src;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave

    // write address phase
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 10'h000;
        end else begin
            wr_pend <= i_hready && i_hsel && i_htrans[1] && i_hwrite;
            if (i_hready && i_hsel && i_htrans[1]) begin
                wr_idx <= i_haddr[11:2];
            end
        end
    end

    // reads take one wait state
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_wait  <= 1'b0;
            rd_idx   <= 10'h000;
            o_hrdata <= 32'h0000_0000;
        end else begin
            rd_wait <= i_hready && i_hsel && i_htrans[1] && !i_hwrite;
            if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
                rd_idx <= i_haddr[11:2];
            end
            if (rd_wait) begin
                o_hrdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign o_hreadyout = !rd_wait;
    assign o_hresp     = 1'b0;
    assign wdat        = i_hwdata[7:0];

    // read decode, unmapped reads zero
    always_comb begin
        case (rd_idx)
            IDX_SRC_CTRL:  rd_byte = src_ctrl;
            IDX_DIV_HIGH:  rd_byte = div_high;
            IDX_DIV_LOW:   rd_byte = div_low;
            IDX_DLY_HIGH:  rd_byte = dly_high;
            IDX_DLY_LOW:   rd_byte = dly_low;
            IDX_BURST_LEN: rd_byte = burst_len;
            IDX_LOOP_FB:   rd_byte = loop_fb;
            IDX_POWER:     rd_byte = power;
            IDX_STATUS:    rd_byte = status;
            IDX_SYNC_CTRL: rd_byte = sync_ctrl;
            default:       rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register file

    // control registers, reserved bits masked
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_ctrl  <= RST_SRC_CTRL;
            div_high  <= RST_DIV_HIGH;
            div_low   <= RST_DIV_LOW;
            dly_high  <= RST_DLY_HIGH;
            dly_low   <= RST_DLY_LOW;
            burst_len <= RST_BURST_LEN;
            loop_fb   <= RST_LOOP_FB;
            power     <= RST_POWER;
            sync_ctrl <= RST_SYNC_CTRL;
        end else if (wr_pend) begin
            case (wr_idx)
                IDX_SRC_CTRL:  src_ctrl  <= wdat & MASK_SRC_CTRL;   // RULE16
                IDX_DIV_HIGH:  div_high  <= wdat & MASK_HIGH;       // RULE16
                IDX_DIV_LOW:   div_low   <= wdat;
                IDX_DLY_HIGH:  dly_high  <= wdat & MASK_HIGH;       // RULE16
                IDX_DLY_LOW:   dly_low   <= wdat;
                IDX_BURST_LEN: burst_len <= wdat & MASK_BURST_LEN;  // RULE16
                IDX_LOOP_FB:   loop_fb   <= wdat & MASK_LOOP_FB;    // RULE16
                IDX_POWER:     power     <= wdat & MASK_POWER;      // RULE16
                IDX_SYNC_CTRL: sync_ctrl <= wdat & MASK_SYNC_CTRL;  // RULE16
                default: begin
                end
            endcase
        end
    end

    // whole values on a low write
    assign div_cand = {div_high[HIGH_FIELD_W-1:0], wdat};  // RULE5
    assign dly_cand = {dly_high[HIGH_FIELD_W-1:0], wdat};  // RULE7

    // commit legal whole values
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sysref_divide_value <= RST_DIVIDE;
            o_sysref_delay_value  <= RST_DELAY;
        end else if (wr_pend) begin
            if (wr_idx == IDX_DIV_LOW && div_cand >= MIN_VALUE) begin  // RULE17
                o_sysref_divide_value <= div_cand;  // RULE6
            end
            if (wr_idx == IDX_DLY_LOW && dly_cand >= MIN_VALUE) begin  // RULE17
                o_sysref_delay_value <= dly_cand;  // RULE7
            end
        end
    end

    // loop selects
    assign o_second_loop_reference_select     = loop_fb[RCLK_SEL_BIT];  // RULE11
    assign o_second_loop_divider_input_select = loop_fb[NCLK2_SEL_BIT];  // RULE12
    assign o_first_loop_divider_input_select  = loop_fb[NCLK1_SEL_LSB +: 2];  // RULE13
    assign o_feedback_mux_ctrl                = loop_fb[FB_CTRL_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // sync conditioning

    pin_sync2 u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_pin      (i_sync_request_pin),
        .o_level    (sync_level)
    );

    // invert, filter, re-clock
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            filt_prev  <= 1'b0;
            filt_level <= 1'b0;
            sync_reclk <= 1'b0;
        end else begin
            filt_prev <= sync_level ^ sync_ctrl[SYNC_INV_BIT];
            if ((sync_level ^ sync_ctrl[SYNC_INV_BIT]) == filt_prev) begin
                filt_level <= filt_prev;
            end
            sync_reclk <= sync_path;
        end
    end

    // bypass
    assign sync_path = src_ctrl[SYNC_BYP_BIT] ? sync_level : filt_level;  // RULE4

    ////////////////////////////////////////////////////////////////////////
    // source selection and power

    assign sysref_up = !power[SYSREF_POWER_DOWN_BIT];                 // RULE14
    assign pulser_up = sysref_up && !power[PULSER_PD_BIT];    // RULE15

    // request pin override
    always_comb begin
        if (src_ctrl[REQ_EN_BIT] && sync_level) begin
            eff_src = SRC_CONT;  // RULE2
        end else begin
            eff_src = sysref_src_t'(src_ctrl[SRC_SEL_LSB +: 2]);  // RULE1
        end
    end

    assign continuous = sysref_up && eff_src == SRC_CONT;
    assign burst_go   = wr_pend && wr_idx == IDX_BURST_LEN && pulser_up
                        && eff_src == SRC_PULSER;  // RULE9

    ////////////////////////////////////////////////////////////////////////
    // pulse generator

    // idle, delay, run
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state      <= ST_IDLE;
            burst_mode <= 1'b0;
            remaining  <= 4'h0;
            dly_count  <= 13'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    dly_count <= 13'h0000;
                    if (continuous) begin
                        state      <= ST_DELAY;
                        burst_mode <= 1'b0;
                    end else if (burst_go) begin
                        state      <= ST_DELAY;
                        burst_mode <= 1'b1;
                        remaining  <= 4'h1 << wdat[1:0];  // RULE8
                    end
                end
                ST_DELAY: begin
                    dly_count <= dly_count + 13'h0001;
                    if (!sysref_up || (burst_mode ? !pulser_up : !continuous)) begin
                        state      <= ST_IDLE;  // RULE14 RULE15
                        burst_mode <= 1'b0;
                    end else if (dly_count == o_sysref_delay_value - 13'h0001) begin
                        state <= ST_RUN;  // RULE7
                    end
                end
                ST_RUN: begin
                    if (continuous) begin
                        state <= ST_RUN;  // RULE10
                    end else if (!burst_mode || !pulser_up) begin
                        state      <= ST_IDLE;  // RULE15
                        burst_mode <= 1'b0;
                    end else if (div_end) begin
                        remaining <= remaining - 4'h1;
                        if (remaining == 4'h1) begin
                            state      <= ST_IDLE;
                            burst_mode <= 1'b0;
                        end
                    end
                end
                default: begin
                    state      <= ST_IDLE;
                    burst_mode <= 1'b0;
                end
            endcase
        end
    end

    sysref_divider u_divider (
        .i_core_clk   (i_core_clk),
        .i_rstn       (i_rstn),
        .i_run        (state == ST_RUN),
        .i_divide     (o_sysref_divide_value),  // RULE6
        .o_level      (div_level),
        .o_period_end (div_end)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // registered outputs
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sysref   <= 1'b0;
            o_sync_out <= 1'b0;
        end else begin
            o_sync_out <= sysref_up && sync_path;  // RULE14
            case (eff_src)
                SRC_SYNC:  o_sysref <= sysref_up && sync_path;    // RULE1
                SRC_RECLK: o_sysref <= sysref_up && sync_reclk;   // RULE1
                SRC_PULSER: o_sysref <= pulser_up && div_level;   // RULE1
                SRC_CONT:  o_sysref <= sysref_up && div_level;    // RULE1
                default:   o_sysref <= 1'b0;
            endcase
        end
    end

    assign o_active_source = eff_src;
    assign o_burst_busy    = burst_mode;
    assign status          = {remaining, state == ST_RUN, burst_mode, eff_src};

endmodule

//--- tb/sysref_sync_feedback_regs_assertions.sv
`timescale 1ns/1ps
module sysref_sync_feedback_regs_assertions (
    // clock and reset
    input wire logic                         i_core_clk,
    input wire logic                         i_rstn,
    // bus
    input wire logic                         i_hsel,
    input wire logic [1:0]                   i_htrans,
    input wire logic                         i_hwrite,
    input wire logic                         i_hready,
    input wire logic                         o_hreadyout,
    input wire logic                         o_hresp,
    input wire logic [31:0]                  o_hrdata,
    // generation and selects
    input wire logic                         o_burst_busy,
    input wire sysref_regs_pkg::sysref_src_t o_active_source,
    input wire logic                         o_second_loop_reference_select,
    input wire logic [1:0]                   o_first_loop_divider_input_select,
    input wire logic [12:0]                  o_sysref_divide_value,
    input wire logic [12:0]                  o_sysref_delay_value
);
    import sysref_regs_pkg::*;

    logic wr_dp;

    ////////////////////////////////////////////////////////////////////////
    // write data phase
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_dp <= 1'b0;
        end else begin
            wr_dp <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////////
    // bus answers
    property p_okay_clean;
        o_hresp == 1'b0 && o_hrdata[31:8] == 24'h000000;
    endproperty
    a_okay_clean: assert property (p_okay_clean)
        else $error("bad response");
    property p_read_wait;
        (i_hsel && i_htrans[1] && i_hready && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait wrong");
    property p_write_nowait;
        (i_hsel && i_htrans[1] && i_hready && i_hwrite) |=> o_hreadyout;
    endproperty
    a_write_nowait: assert property (p_write_nowait)
        else $error("write stalled");

    ////////////////////////////////////////////////////////////////////////
    // committed values, selects and burst start
    property p_div_legal;
        o_sysref_divide_value >= MIN_VALUE;
    endproperty
    a_div_legal: assert property (p_div_legal)
        else $error("reserved divide");
    property p_dly_legal;
        o_sysref_delay_value >= MIN_VALUE;
    endproperty
    a_dly_legal: assert property (p_dly_legal)
        else $error("reserved delay");
    property p_div_on_write;
        !$stable({o_sysref_divide_value, o_sysref_delay_value}) |-> $past(wr_dp);
    endproperty
    a_div_on_write: assert property (p_div_on_write)
        else $error("value changed unwritten");
    property p_sel_on_write;
        !$stable({o_second_loop_reference_select, o_first_loop_divider_input_select})
            |-> $past(wr_dp);
    endproperty
    a_sel_on_write: assert property (p_sel_on_write)
        else $error("select changed unwritten");
    property p_burst_start;
        $rose(o_burst_busy) |-> $past(wr_dp) && $past(o_active_source) == SRC_PULSER;
    endproperty
    a_burst_start: assert property (p_burst_start)
        else $error("stray burst");
endmodule

//--- tb/sysref_sync_feedback_regs_bench.sv
`timescale 1ns/1ps
module sysref_sync_feedback_regs_bench;
    import sysref_regs_pkg::*;

    // stimulus
    logic        core_clk, rstn, hsel, hwrite, sync_pin;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    // design outputs
    logic        hready, hresp, sysref, sync_out, busy, ref_sel, nsel2;
    logic [31:0] hrdata;
    logic [1:0]  nsel1;
    logic [2:0]  fb_ctrl;
    logic [12:0] div_val, dly_val;
    sysref_src_t act_src;
    // model and bookkeeping
    logic [7:0]  mdl [int];
    logic [7:0]  d;
    logic [7:0]  fb_vals [4] = '{8'hA8, 8'h10, 8'hFF, 8'h00};
    int          idx_list [$] = '{10'h139, 10'h13A, 10'h13B, 10'h13C, 10'h13D, 10'h13E,
                                  10'h13F, 10'h140, 10'h151, 10'h145, 10'h100};
    int          seq [$] = '{20'h13AFF, 20'h13BFF, 20'h13A00, 20'h13B05, 20'h13B08,
                             20'h13C1F, 20'h13DFF, 20'h13C00, 20'h13D07, 20'h13D08};
    int          div_exp, dly_exp, miscompares, checked, cycles, seed, s, n;

    sysref_sync_feedback_regs sysref_sync_feedback_regs_inst (
        .i_core_clk(core_clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_sync_request_pin(sync_pin), .o_sysref(sysref), .o_sync_out(sync_out),
        .o_active_source(act_src), .o_burst_busy(busy),
        .o_second_loop_reference_select(ref_sel), .o_second_loop_divider_input_select(nsel2),
        .o_first_loop_divider_input_select(nsel1), .o_feedback_mux_ctrl(fb_ctrl),
        .o_sysref_divide_value(div_val), .o_sysref_delay_value(dly_val));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] wmask(input int idx);
        case (idx)
            IDX_SRC_CTRL: wmask = MASK_SRC_CTRL;
            IDX_DIV_HIGH, IDX_DLY_HIGH: wmask = MASK_HIGH;
            IDX_BURST_LEN: wmask = MASK_BURST_LEN;
            IDX_LOOP_FB: wmask = MASK_LOOP_FB;
            IDX_POWER: wmask = MASK_POWER;
            IDX_SYNC_CTRL: wmask = MASK_SYNC_CTRL;
            default: wmask = 8'hFF;
        endcase
    endfunction

    // one single word transfer, hready sampled at rising edges
    task automatic bus(input int idx, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {20'h00000, 10'(idx), 2'b00};
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // write, model, compare
    task automatic wr(input int idx, input logic [7:0] wd);
        logic [31:0] rd;
        int v;
        bus(idx, 1'b1, wd, rd);
        if (mdl.exists(idx)) mdl[idx] = wd & wmask(idx);
        if (idx == IDX_DIV_LOW || idx == IDX_DLY_LOW) begin
            v = {mdl[idx-1][4:0], mdl[idx]};
            if (v >= 8 && idx == IDX_DIV_LOW) div_exp = v;
            if (v >= 8 && idx == IDX_DLY_LOW) dly_exp = v;
        end
        @(negedge core_clk);
        chk("divide", div_exp, 32'(div_val));
        chk("delay", dly_exp, 32'(dly_val));
    endtask

    task automatic rd_chk(input int idx);
        logic [31:0] rd;
        bus(idx, 1'b0, 8'h00, rd);
        chk($sformatf("reg %h", idx), mdl.exists(idx) ? 32'(mdl[idx]) : 32'h0, rd);
    endtask

    task automatic pin(input logic v, input int k);
        @(posedge core_clk);
        sync_pin <= v;
        repeat (k) @(negedge core_clk);
    endtask

    task automatic settle(input int k);
        repeat (k) @(negedge core_clk);
    endtask

    task automatic count_rises(input int win, output int cnt);
        logic prev;
        prev = sysref;
        cnt = 0;
        repeat (win) begin
            @(negedge core_clk);
            if (sysref && !prev) cnt++;
            prev = sysref;
        end
    endtask

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 32'h8dba;
        {core_clk, rstn, hsel, hwrite, sync_pin, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        {cycles, miscompares, checked} = '0;
        mdl = '{IDX_SRC_CTRL: RST_SRC_CTRL, IDX_DIV_HIGH: RST_DIV_HIGH, IDX_DIV_LOW: RST_DIV_LOW,
                IDX_DLY_HIGH: RST_DLY_HIGH, IDX_DLY_LOW: RST_DLY_LOW, IDX_BURST_LEN: RST_BURST_LEN,
                IDX_LOOP_FB: RST_LOOP_FB, IDX_POWER: RST_POWER, IDX_SYNC_CTRL: RST_SYNC_CTRL};
        div_exp = RST_DIVIDE;
        dly_exp = RST_DELAY;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk("divide", div_exp, 32'(div_val));
        chk("source", SRC_SYNC, 32'(act_src));
        // reset values, random access
        foreach (idx_list[k]) rd_chk(idx_list[k]);
        foreach (idx_list[k]) begin
            d = 8'($random(seed));
            if (idx_list[k] == IDX_SRC_CTRL) d[1:0] = 2'b00;
            wr(idx_list[k], d);
            rd_chk(idx_list[k]);
        end
        // split values
        foreach (seq[k]) wr(seq[k] >> 8, seq[k][7:0]);
        // loop input selects
        foreach (fb_vals[k]) begin
            wr(IDX_LOOP_FB, fb_vals[k]);
            chk("ref sel", 32'(fb_vals[k][7]), 32'(ref_sel));
            chk("n2 sel", 32'(fb_vals[k][5]), 32'(nsel2));
            chk("n1 sel", 32'(fb_vals[k][4:3]), 32'(nsel1));
            chk("fb ctrl", 32'(fb_vals[k][2:0]), 32'(fb_ctrl));
            rd_chk(IDX_LOOP_FB);
        end
        // every source
        wr(IDX_POWER, 8'h00);
        for (s = 0; s < 4; s++) begin
            wr(IDX_SRC_CTRL, 8'(s));
            chk("source", s, 32'(act_src));
        end
        wr(IDX_BURST_LEN, 8'h03);
        chk("busy", 0, 32'(busy));
        count_rises(120, n);
        chk("continuous", 1, 32'(n > 8));
        // bursts of every length
        wr(IDX_SRC_CTRL, 8'h02);
        settle(16);
        for (s = 0; s < 4; s++) begin
            wr(IDX_BURST_LEN, 8'(s));
            chk("busy", 1, 32'(busy));
            count_rises(120, n);
            chk("pulses", 1 << s, n);
            chk("busy", 0, 32'(busy));
        end
        // pulser off
        wr(IDX_POWER, 8'h01);
        wr(IDX_BURST_LEN, 8'h00);
        count_rises(40, n);
        chk("pulses", 0, n);
        // request pin override
        wr(IDX_POWER, 8'h00);
        wr(IDX_SRC_CTRL, 8'h12);
        pin(1'b1, 4);
        chk("source", SRC_CONT, 32'(act_src));
        pin(1'b0, 4);
        chk("source", SRC_PULSER, 32'(act_src));
        // sync conditioning
        for (s = 0; s < 8; s++) begin
            wr(IDX_SRC_CTRL, {4'h0, s[2], 3'b000});
            wr(IDX_SYNC_CTRL, 8'(s[1]));
            pin(s[0], 8);
            chk("sync", 32'(s[0] ^ (s[1] & !s[2])), 32'(sync_out));
        end
        wr(IDX_POWER, 8'h04);
        settle(4);
        chk("sync", 0, 32'(sync_out));
        conclude();
    end
endmodule

bind sysref_sync_feedback_regs sysref_sync_feedback_regs_assertions
    sysref_sync_feedback_regs_assertions_inst (.*);
